// ===== hbridge_prot_pkg.sv
package hbridge_prot_pkg;
	localparam int CLK_PERIOD_PS        = 4000;
	localparam int DEAD_TIME_NS         = 200;
	localparam int DEAD_CYC             = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DEAD_CNT_W           = 8;
	// Blank setting arrives in tenths of a kilohm
	localparam int BLANK_SET_W          = 11;
	localparam int BLANK_SET_MIN        = 165;
	localparam int BLANK_SET_MAX        = 1230;
	localparam int BLANK_SET_RST        = 220;
	localparam int BLANK_SLOPE_PS_TENTH = 8860;
	localparam int BLANK_OFFSET_PS      = 58600;
	localparam int BLANK_CNT_W          = 12;
	localparam int SYNC_W               = 7 + BLANK_SET_W;
	typedef enum logic [1:0] {
		LEG_OFF,
		LEG_HIGH,
		LEG_LOW
	} leg_drive_t;
	typedef enum {
		ST_OFF,
		ST_RUN
	} ctrl_state_t;
endpackage

// ===== hbridge_dead_leg.sv
`timescale 1ns/1ps
module hbridge_dead_leg #(
	parameter int DEAD = hbridge_prot_pkg::DEAD_CYC
) (
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rst_n,
	// Requested leg drive
	input  wire hbridge_prot_pkg::leg_drive_t want,
	// Gate controls
	output logic                              hi_r,
	output logic                              lo_r
);
	localparam int DEAD_CNT_W = hbridge_prot_pkg::DEAD_CNT_W;

	logic [hbridge_prot_pkg::DEAD_CNT_W-1:0] cnt_r;
	logic [hbridge_prot_pkg::DEAD_CNT_W-1:0] cnt_nxt;
	logic                                    hi_nxt;
	logic                                    lo_nxt;

	// Every turn-off reloads the gap, so any new switch-on waits it out
	always_comb begin
		hi_nxt  = hi_r;
		lo_nxt  = lo_r;
		cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
		if (hi_r && want != hbridge_prot_pkg::LEG_HIGH) begin
			hi_nxt  = 1'b0;
			cnt_nxt = DEAD_CNT_W'(DEAD - 1);
		end else if (lo_r && want != hbridge_prot_pkg::LEG_LOW) begin
			lo_nxt  = 1'b0;
			cnt_nxt = DEAD_CNT_W'(DEAD - 1);
		end else if (!hi_r && !lo_r && cnt_r == '0) begin
			hi_nxt = (want == hbridge_prot_pkg::LEG_HIGH);
			lo_nxt = (want == hbridge_prot_pkg::LEG_LOW);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_r  <= 1'b0;
			lo_r  <= 1'b0;
			cnt_r <= '0;
		end else begin
			hi_r  <= hi_nxt;
			lo_r  <= lo_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Checking helpers
	logic [7:0] off_run_r;
	logic       last_lo_r;
	logic       last_hi_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			off_run_r <= '0;
			last_lo_r <= 1'b0;
			last_hi_r <= 1'b0;
		end else begin
			off_run_r <= (hi_r || lo_r) ? 8'h00 : ((off_run_r == 8'hff) ? off_run_r : off_run_r + 8'h01);
			last_lo_r <= lo_r ? 1'b1 : (hi_r ? 1'b0 : last_lo_r);
			last_hi_r <= hi_r ? 1'b1 : (lo_r ? 1'b0 : last_hi_r);
		end
	end

	chk_no_shoot: assert property (@(posedge core_clk) disable iff (!rst_n) !(hi_r && lo_r))
		else $error("both switches of a leg on");
	chk_gap_lo_hi: assert property (@(posedge core_clk) disable iff (!rst_n)
		($rose(hi_r) && last_lo_r) |-> (off_run_r >= 8'(DEAD)))
		else $error("high switch on before dead time");
	chk_gap_hi_lo: assert property (@(posedge core_clk) disable iff (!rst_n)
		($rose(lo_r) && last_hi_r) |-> (off_run_r >= 8'(DEAD)))
		else $error("low switch on before dead time");
	cov_reversal: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(hi_r) && last_lo_r);
endmodule // hbridge_dead_leg

// ===== hbridge_fault_protection.sv
`timescale 1ns/1ps
module hbridge_fault_protection (
	// Clock and reset
	input  wire logic                                   core_clk,
	input  wire logic                                   rst_n,
	// Host pins
	input  wire logic                                   power_down_n,
	input  wire logic                                   mode_select,
	input  wire logic                                   direction_in_a,
	input  wire logic                                   direction_in_b,
	input  wire logic [hbridge_prot_pkg::BLANK_SET_W-1:0] overcurrent_blank_set,
	// Analog comparators
	input  wire logic                                   undervoltage_lockout,
	input  wire logic                                   thermal_shutdown,
	input  wire logic                                   overcurrent_trip,
	// Bridge gate controls
	output logic                                        bridge_output_a_hi_r,
	output logic                                        bridge_output_a_lo_r,
	output logic                                        bridge_output_b_hi_r,
	output logic                                        bridge_output_b_lo_r,
	// Supply enables
	output logic                                        regulator_en_r,
	output logic                                        charge_pump_en_r,
	// Fault indicator, open drain
	output logic                                        fault_flag_r,
	output logic                                        fault_pin_out_r,
	output logic                                        fault_pin_oe_r
);
	localparam int BW = hbridge_prot_pkg::BLANK_CNT_W;
	localparam int SW = hbridge_prot_pkg::BLANK_SET_W;

	function automatic logic [BW-1:0] blank_cycles(input logic [SW-1:0] set);
		int r;
		int ps;
		r = int'(set);
		if (r < hbridge_prot_pkg::BLANK_SET_MIN) r = hbridge_prot_pkg::BLANK_SET_MIN;
		if (r > hbridge_prot_pkg::BLANK_SET_MAX) r = hbridge_prot_pkg::BLANK_SET_MAX;
		ps = r * hbridge_prot_pkg::BLANK_SLOPE_PS_TENTH + hbridge_prot_pkg::BLANK_OFFSET_PS;
		return BW'((ps + hbridge_prot_pkg::CLK_PERIOD_PS - 1) / hbridge_prot_pkg::CLK_PERIOD_PS);
	endfunction

	// All pins pass two flops; the first stage feeds only the second
	logic [hbridge_prot_pkg::SYNC_W-1:0] meta_r;
	logic [hbridge_prot_pkg::SYNC_W-1:0] sync_r;
	logic [hbridge_prot_pkg::SYNC_W-1:0] pin_vec;
	logic                                s_pd_n;
	logic                                s_sel;
	logic                                s_ina;
	logic                                s_inb;
	logic                                s_uv;
	logic                                s_tsd;
	logic                                s_oc;
	logic [SW-1:0]                       s_blank;

	assign pin_vec = {overcurrent_blank_set, overcurrent_trip, thermal_shutdown,
		undervoltage_lockout, direction_in_b, direction_in_a, mode_select, power_down_n};
	assign {s_blank, s_oc, s_tsd, s_uv, s_inb, s_ina, s_sel, s_pd_n} = sync_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= {SW'(hbridge_prot_pkg::BLANK_SET_RST), 7'h01};
			sync_r <= {SW'(hbridge_prot_pkg::BLANK_SET_RST), 7'h01};
		end else begin
			meta_r <= pin_vec;
			sync_r <= meta_r;
		end
	end

	// Control and protection state
	hbridge_prot_pkg::ctrl_state_t state_r;
	hbridge_prot_pkg::ctrl_state_t state_nxt;
	logic                          pd_d_r;
	logic                          tsd_latch_r;
	logic                          tsd_latch_nxt;
	logic                          oc_latch_r;
	logic                          oc_latch_nxt;
	logic [BW-1:0]                 oc_cnt_r;
	logic [BW-1:0]                 oc_cnt_nxt;
	logic [BW-1:0]                 blank_r;
	logic                          pd_rise;
	logic                          clean_start;
	logic                          running;
	logic                          oc_done;
	logic                          any_fault;
	hbridge_prot_pkg::leg_drive_t  want_a;
	hbridge_prot_pkg::leg_drive_t  want_b;

	assign pd_rise     = s_pd_n && !pd_d_r;
	assign clean_start = s_uv || !s_pd_n || pd_rise;
	assign running     = (state_r == hbridge_prot_pkg::ST_RUN);
	assign oc_done     = s_oc && (oc_cnt_r + 1'b1 >= blank_r);
	assign any_fault   = tsd_latch_r || oc_latch_r || s_uv || !s_pd_n || !running;

	always_comb begin
		state_nxt     = (s_uv || !s_pd_n) ? hbridge_prot_pkg::ST_OFF : hbridge_prot_pkg::ST_RUN;
		tsd_latch_nxt = tsd_latch_r;
		oc_latch_nxt  = oc_latch_r;
		oc_cnt_nxt    = '0;
		if (clean_start) begin
			tsd_latch_nxt = 1'b0;
			oc_latch_nxt  = 1'b0;
		end
		if (!s_uv && s_pd_n) begin
			if (s_oc && !oc_done) oc_cnt_nxt = oc_cnt_r + 1'b1;
			// A trip in the release cycle still wins
			if (s_tsd) tsd_latch_nxt = 1'b1;
			if (oc_done) oc_latch_nxt = 1'b1;
		end
		if (s_uv) begin
			tsd_latch_nxt = 1'b0;
			oc_latch_nxt  = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= hbridge_prot_pkg::ST_OFF;
			pd_d_r      <= 1'b1;
			tsd_latch_r <= 1'b0;
			oc_latch_r  <= 1'b0;
			oc_cnt_r    <= '0;
			blank_r     <= blank_cycles(SW'(hbridge_prot_pkg::BLANK_SET_RST));
		end else begin
			state_r     <= state_nxt;
			pd_d_r      <= s_pd_n;
			tsd_latch_r <= tsd_latch_nxt;
			oc_latch_r  <= oc_latch_nxt;
			oc_cnt_r    <= oc_cnt_nxt;
			blank_r     <= blank_cycles(s_blank);
		end
	end

	// Mode decode; select low is parallel, high complemental
	always_comb begin
		want_a = hbridge_prot_pkg::LEG_OFF;
		want_b = hbridge_prot_pkg::LEG_OFF;
		unique case ({s_sel, s_ina, s_inb})
			3'h0: begin
			end
			3'h1, 3'h7: begin
				want_a = hbridge_prot_pkg::LEG_LOW;
				want_b = hbridge_prot_pkg::LEG_HIGH;
			end
			3'h2, 3'h6: begin
				want_a = hbridge_prot_pkg::LEG_HIGH;
				want_b = hbridge_prot_pkg::LEG_LOW;
			end
			3'h3, 3'h4, 3'h5: begin
				want_a = hbridge_prot_pkg::LEG_LOW;
				want_b = hbridge_prot_pkg::LEG_LOW;
			end
		endcase
		if (any_fault) begin
			want_a = hbridge_prot_pkg::LEG_OFF;
			want_b = hbridge_prot_pkg::LEG_OFF;
		end
	end

	hbridge_dead_leg #(.DEAD(hbridge_prot_pkg::DEAD_CYC)) u_leg_a (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.want     (want_a),
		.hi_r     (bridge_output_a_hi_r),
		.lo_r     (bridge_output_a_lo_r)
	);

	hbridge_dead_leg #(.DEAD(hbridge_prot_pkg::DEAD_CYC)) u_leg_b (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.want     (want_b),
		.hi_r     (bridge_output_b_hi_r),
		.lo_r     (bridge_output_b_lo_r)
	);

	// Supply enables and fault indicator
	logic fault_nxt;
	logic supply_nxt;
	assign fault_nxt  = tsd_latch_nxt || oc_latch_nxt;
	assign supply_nxt = !s_uv && s_pd_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			regulator_en_r   <= 1'b0;
			charge_pump_en_r <= 1'b0;
			fault_flag_r     <= 1'b0;
			fault_pin_out_r  <= 1'b0;
			fault_pin_oe_r   <= 1'b1;
		end else begin
			regulator_en_r   <= supply_nxt;
			charge_pump_en_r <= supply_nxt;
			fault_flag_r     <= fault_nxt;
			fault_pin_out_r  <= 1'b0;
			// Released pin is pulled high externally
			fault_pin_oe_r   <= !fault_nxt;
		end
	end

	logic bridge_on;
	assign bridge_on = bridge_output_a_hi_r || bridge_output_a_lo_r
		|| bridge_output_b_hi_r || bridge_output_b_lo_r;

	chk_uv_disables: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_uv |=> (!regulator_en_r && !charge_pump_en_r && !bridge_on))
		else $error("undervoltage did not disable supplies and bridge");
	chk_uv_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_uv |=> (!tsd_latch_r && !oc_latch_r && state_r == hbridge_prot_pkg::ST_OFF))
		else $error("undervoltage did not reset protection state");
	chk_tsd_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
		(running && s_tsd && !s_uv && s_pd_n) |=> tsd_latch_r ##1 !bridge_on)
		else $error("overtemperature did not latch and tri-state");
	chk_tsd_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		(tsd_latch_r && !s_uv && s_pd_n && !pd_rise) |=> tsd_latch_r)
		else $error("thermal latch cleared without restart");
	chk_oc_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		(oc_latch_r && !$past(clean_start) && !clean_start) |=> oc_latch_r)
		else $error("overcurrent latch cleared without restart");
	chk_oc_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(oc_latch_r) |-> ($past(oc_cnt_r) + 1'b1 == blank_r))
		else $error("overcurrent latched before blanking time");
	chk_oc_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
		!s_oc |=> (oc_cnt_r == '0))
		else $error("blanking count did not restart");
	chk_blank_range: assert property (@(posedge core_clk) disable iff (!rst_n)
		(blank_r >= BW'(381) && blank_r <= BW'(2740)))
		else $error("blanking count outside range");
	chk_flag_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
		(fault_flag_r == (tsd_latch_r || oc_latch_r)) && (fault_pin_oe_r == !fault_flag_r))
		else $error("fault indicator wrong");
	chk_fault_hiz: assert property (@(posedge core_clk) disable iff (!rst_n)
		(tsd_latch_r || oc_latch_r || !s_pd_n) |=> !bridge_on)
		else $error("bridge driven during fault or power-down");

	cov_tsd_trip: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(tsd_latch_r));
	cov_oc_trip: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(oc_latch_r));
	cov_wake_clear: cover property (@(posedge core_clk) disable iff (!rst_n) oc_latch_r && pd_rise);
endmodule // hbridge_fault_protection

// ===== bridge_stage_model.sv
`timescale 1ns/1ps
module bridge_stage_model (
	// Gate controls
	input  wire logic a_hi,
	input  wire logic a_lo,
	input  wire logic b_hi,
	input  wire logic b_lo,
	// Open-drain flag pin
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output wire logic fault_pin,
	output logic      shoot_through
);
	// Pull-up wins whenever the driver lets go
	assign fault_pin = pin_oe ? pin_out : 1'b1;
	// Sticky, so a one-cycle overlap is never missed
	initial begin
		shoot_through = 1'b0;
		forever begin
			@(a_hi or a_lo or b_hi or b_lo);
			if ((a_hi && a_lo) || (b_hi && b_lo)) shoot_through = 1'b1;
		end
	end
endmodule // bridge_stage_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
	logic        core_clk, rst_n, power_down_n, mode_select, direction_in_a, direction_in_b;
	logic        undervoltage_lockout, thermal_shutdown, overcurrent_trip;
	logic [10:0] overcurrent_blank_set;
	logic        a_hi, a_lo, b_hi, b_lo, regulator_en_r, charge_pump_en_r;
	logic        fault_flag_r, pin_out, pin_oe, fault_pin, shoot;
	logic [3:0]  gates;
	int          num_errors, checks, cycles, n;
	logic [3:0]  mode_exp [8] = '{4'h0, 4'h6, 4'h9, 4'h5, 4'h5, 4'h5, 4'h9, 4'h6};
	int          blank_sets [3] = '{165, 220, 1230};

	assign gates = {a_hi, a_lo, b_hi, b_lo};
	hbridge_fault_protection uut (.core_clk(core_clk), .rst_n(rst_n),
		.power_down_n(power_down_n), .mode_select(mode_select),
		.direction_in_a(direction_in_a), .direction_in_b(direction_in_b),
		.overcurrent_blank_set(overcurrent_blank_set),
		.undervoltage_lockout(undervoltage_lockout), .thermal_shutdown(thermal_shutdown),
		.overcurrent_trip(overcurrent_trip), .bridge_output_a_hi_r(a_hi),
		.bridge_output_a_lo_r(a_lo), .bridge_output_b_hi_r(b_hi), .bridge_output_b_lo_r(b_lo),
		.regulator_en_r(regulator_en_r), .charge_pump_en_r(charge_pump_en_r),
		.fault_flag_r(fault_flag_r), .fault_pin_out_r(pin_out), .fault_pin_oe_r(pin_oe));
	bridge_stage_model stage (.a_hi(a_hi), .a_lo(a_lo), .b_hi(b_hi), .b_lo(b_lo),
		.pin_out(pin_out), .pin_oe(pin_oe), .fault_pin(fault_pin), .shoot_through(shoot));

	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	task automatic tally_and_finish;
		$display("Errors: %0d, checks: %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Ceiling well above the longest blanking run plus the rest
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish;
		end
	end

	task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_range(string what, int lo, int hi, int got);
		checks++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic wait_cyc(int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	task automatic pins(logic [2:0] m);
		@(posedge core_clk);
		{mode_select, direction_in_a, direction_in_b} <= m;
	endtask

	task automatic pulse_thermal;
		@(posedge core_clk);
		thermal_shutdown <= 1'b1;
		@(posedge core_clk);
		thermal_shutdown <= 1'b0;
	endtask

	// Sleep cycle with host pins held low over the wake
	task automatic wake;
		@(posedge core_clk);
		power_down_n <= 1'b0;
		{mode_select, direction_in_a, direction_in_b} <= 3'b000;
		wait_cyc(6);
		chk("gates asleep", 4'h0, gates);
		chk("enables asleep", 4'h0, {2'b00, regulator_en_r, charge_pump_en_r});
		@(posedge core_clk);
		power_down_n <= 1'b1;
		wait_cyc(70);
		chk("flag after wake", 4'h0, {3'b000, fault_flag_r});
	endtask

	task automatic trip(int set);
		int b;
		b = (hbridge_prot_pkg::BLANK_SLOPE_PS_TENTH * set + hbridge_prot_pkg::BLANK_OFFSET_PS
			+ hbridge_prot_pkg::CLK_PERIOD_PS - 1) / hbridge_prot_pkg::CLK_PERIOD_PS;
		@(posedge core_clk);
		overcurrent_blank_set <= 11'(set);
		{mode_select, direction_in_a, direction_in_b} <= 3'b010;
		wait_cyc(9);
		chk("gates before trip", 4'h9, gates);
		@(posedge core_clk);
		overcurrent_trip <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (fault_flag_r !== 1'b1 && n < 3000);
		chk_range("trip cycles", b, b + 5, n);
		wait_cyc(2);
		chk("gates tripped", 4'h0, gates);
		// Load fault removed before any release
		@(posedge core_clk);
		overcurrent_trip <= 1'b0;
		wait_cyc(20);
		chk("latch held", 4'h1, {3'b000, fault_flag_r});
		chk("pin released", 4'h1, {3'b000, fault_pin});
	endtask

	initial begin
		{rst_n, mode_select, direction_in_a, direction_in_b} = 4'h0;
		{undervoltage_lockout, thermal_shutdown, overcurrent_trip} = 3'h0;
		power_down_n = 1'b1;
		overcurrent_blank_set = 11'h0dc;
		num_errors = 0;
		checks = 0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		wait_cyc(70);
		chk("enables on", 4'h3, {2'b00, regulator_en_r, charge_pump_en_r});
		chk("pin low", 4'h0, {3'b000, fault_pin});
		for (int m = 0; m < 8; m++) begin
			pins(3'(m));
			wait_cyc(70);
			chk("mode gates", mode_exp[m], gates);
		end
		pins(3'b010);
		wait_cyc(70);
		pins(3'b001);
		wait_cyc(10);
		chk("dead gap", 4'h0, gates);
		n = 10;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (gates !== 4'h6 && n < 200);
		chk_range("dead time cycles", hbridge_prot_pkg::DEAD_CYC + 3, 56, n);
		pins(3'b010);
		wait_cyc(70);
		pulse_thermal();
		wait_cyc(8);
		chk("gates thermal", 4'h0, gates);
		chk("flag thermal", 4'h1, {3'b000, fault_flag_r});
		wait_cyc(100);
		chk("thermal held", 4'h1, {3'b000, fault_flag_r});
		wake();
		pins(3'b010);
		wait_cyc(70);
		chk("drive after wake", 4'h9, gates);
		// Two sub-blank bursts; a count that never restarts would trip
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			overcurrent_trip <= 1'b1;
			repeat (400) @(posedge core_clk);
			overcurrent_trip <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
		wait_cyc(10);
		chk("short bursts", 4'h0, {3'b000, fault_flag_r});
		chk("still driving", 4'h9, gates);
		foreach (blank_sets[i]) begin
			trip(blank_sets[i]);
			wake();
		end
		pins(3'b010);
		wait_cyc(70);
		pulse_thermal();
		wait_cyc(5);
		@(posedge core_clk);
		undervoltage_lockout <= 1'b1;
		wait_cyc(8);
		chk("gates uv", 4'h0, gates);
		chk("enables uv", 4'h0, {2'b00, regulator_en_r, charge_pump_en_r});
		chk("latch cleared uv", 4'h0, {3'b000, fault_flag_r});
		@(posedge core_clk);
		undervoltage_lockout <= 1'b0;
		wait_cyc(70);
		chk("drive after uv", 4'h9, gates);
		chk("no overlap", 4'h0, {3'b000, shoot});
		tally_and_finish;
	end
endmodule // tb
